/* src/mkey_pkg.sv */
package mkey_pkg;

  // ==========================================================
  // matrix geometry
  localparam int MKEY_NUM_POS = 10;
  localparam int MKEY_NUM_GRP = 10;
  localparam int MKEY_NUM_BITS = MKEY_NUM_POS * MKEY_NUM_GRP;
  localparam int MKEY_STANDBY_BIT = 0;
  localparam int MKEY_CARRY_HI = 4;
  localparam int MKEY_IDX_W = 4;

  // ==========================================================
  // interval divider: ratio 16,384, output rises at 8,192
  localparam int MKEY_DIV_LOG2 = 14;
  localparam logic [13:0] MKEY_DIV_RST = 14'h0000;

  // ==========================================================
  // element fifo
  localparam int MKEY_FIFO_DEPTH = 16;

  // ==========================================================
  // reset values
  localparam logic [9:0] MKEY_ONEHOT_RST = 10'h001;
  localparam logic MKEY_KEY_RST = 1'b0;

  // run latch states, gray along standby -> run -> standby
  typedef enum logic {
    MKEY_STANDBY = 1'b0,
    MKEY_RUN = 1'b1
  } mkey_latch_t;

  // one finished code element
  typedef struct packed {
    logic key;
    logic [3:0] grp;
    logic [3:0] pos;
  } mkey_elem_t;

  localparam int MKEY_ELEM_W = $bits(mkey_elem_t);

endpackage

/* src/mkey_keyer.sv */
// Operation
// - power-up holds the run latch in standby, both counters held reset
// - a trigger releases the latch and both counter resets, starting output
// - group counter carry rising edge returns the latch to standby
// - each counter shows ten decoded outputs, exactly one active
// - a held counter shows its first output and does not count
// - an inhibit input high freezes a counter; counting only when low
// - released counters step once per rising clock edge from position zero while the fifo has room
// - from last position the next edge wraps to zero and raises carry
// - the position counter carry clocks the group counter
// - pattern is ten groups of ten bits, group and position select one
// - keyed output high for a programmed bit, low for an empty one
// - standby bit of the first group is never programmable
// - manual switch or interval pulse both trigger the latch alike
// - keyed output gates the tone; a manual tone key also exists
// - interval divider rises at half count, falls at full count
// - trigger forms on divider falling edge, suppressed at power-up
// - manual trigger leaves the divider alone; divider cleared at power-up
`timescale 1ns/100ps

// ============================================================
// element fifo
module mkey_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = DEPTH[AW:0];

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic push;
  logic pop;
  logic [AW-1:0] rd_nxt;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // head pointer as it stands after this edge's pop
  always_comb begin
    rd_nxt = rd_ptr_r;
    if (pop) begin
      rd_nxt = rd_ptr_r + 1'b1;
    end
  end

  // head word registered so the port comes from a flop; a push into
  // the slot that becomes the head is forwarded, because storage is
  // only written at this same edge and would show the stale word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_data <= '0;
    end else if (push && (wr_ptr_r == rd_nxt)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem_r[rd_nxt];
    end
  end

  // occupancy follows push and pop together
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // flags registered so the ports come straight from flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count_r <= count_nxt;
      in_ready <= (count_nxt != DEPTH_CNT);
      out_valid <= (count_nxt != '0);
    end
  end

  // pointers wrap at a power-of-two depth
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // storage has no reset; an unwritten slot reaches out_data only while out_valid is low
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule

// ============================================================
// keyer top
module mkey_keyer
  import mkey_pkg::*;
#(
  parameter int DIV_LOG2 = MKEY_DIV_LOG2,
  parameter int FIFO_DEPTH = MKEY_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic code_clk,
  input wire logic interval_clk,
  input wire logic manual_trigger_switch,
  input wire logic tone_gate_switch,
  input wire logic position_inhibit,
  input wire logic group_inhibit,
  input wire logic [MKEY_NUM_BITS-1:0] pattern_bits,
  output logic keyed_out,
  output logic tone_gate,
  output logic standby,
  output logic [MKEY_NUM_POS-1:0] position_counter,
  output logic [MKEY_NUM_GRP-1:0] group_counter,
  output logic elem_valid,
  input wire logic elem_ready,
  output mkey_elem_t elem_data
);

  // one-hot to index, for the element record
  function automatic logic [MKEY_IDX_W-1:0] mkey_index(
    input logic [9:0] oh
  );
    logic [MKEY_IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < 10; i++) begin
      if (oh[i]) begin
        idx = i[MKEY_IDX_W-1:0];
      end
    end
    return idx;
  endfunction

  mkey_latch_t latch_r;
  logic code_prev_r;
  logic ival_prev_r;
  logic manual_prev_r;
  logic [DIV_LOG2-1:0] div_r;
  logic div_out_prev_r;
  logic pos_carry_prev_r;
  logic grp_carry_prev_r;
  logic [MKEY_NUM_POS-1:0] pos_nxt;
  logic [MKEY_NUM_GRP-1:0] grp_nxt;
  logic [MKEY_NUM_BITS-1:0] store;
  logic [MKEY_NUM_BITS-1:0] sel_bits;
  logic key_now;
  logic code_rise;
  logic interval_rise;
  logic manual_rise;
  logic timer_trigger;
  logic trigger;
  logic pos_carry;
  logic grp_carry;
  logic pos_carry_rise;
  logic grp_carry_rise;
  logic pos_step;
  logic held;
  logic fifo_in_ready;
  mkey_elem_t elem_in;

  // ==========================================================
  // synchronous edge detection of slow clocks and switch
  assign code_rise = code_clk & ~code_prev_r;
  assign interval_rise = interval_clk & ~ival_prev_r;
  assign manual_rise = manual_trigger_switch & ~manual_prev_r;

  // manual switch held at power-up must not fire, so its history
  // starts high
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      code_prev_r <= 1'b0;
      ival_prev_r <= 1'b0;
      manual_prev_r <= 1'b1;
    end else begin
      code_prev_r <= code_clk;
      ival_prev_r <= interval_clk;
      manual_prev_r <= manual_trigger_switch;
    end
  end

  // ==========================================================
  // interval divider; top bit high from half count to full count
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= '0;
    end else if (interval_rise) begin
      div_r <= div_r + 1'b1;
    end
  end

  // falling edge of the divider output is the timer pulse; history
  // starts low so reset itself never yields one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_out_prev_r <= 1'b0;
    end else begin
      div_out_prev_r <= div_r[DIV_LOG2-1];
    end
  end

  assign timer_trigger = div_out_prev_r & ~div_r[DIV_LOG2-1];
  // the manual path never touches the divider
  assign trigger = timer_trigger | manual_rise;

  // ==========================================================
  // run latch
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_r <= MKEY_STANDBY;
    end else begin
      unique case (latch_r)
        MKEY_STANDBY: begin
          if (trigger) begin
            latch_r <= MKEY_RUN;
          end
        end
        MKEY_RUN: begin
          // further triggers are ignored here
          if (grp_carry_rise) begin
            latch_r <= MKEY_STANDBY;
          end
        end
      endcase
    end
  end

  assign held = (latch_r == MKEY_STANDBY);

  // ==========================================================
  // decade counters; carry high over the first five positions,
  // so it rises exactly when last wraps to first
  assign pos_carry = |position_counter[MKEY_CARRY_HI:0];
  assign grp_carry = |group_counter[MKEY_CARRY_HI:0];
  assign pos_carry_rise = pos_carry & ~pos_carry_prev_r;
  assign grp_carry_rise = grp_carry & ~grp_carry_prev_r;

  // a full fifo stalls the sequence instead of dropping elements
  assign pos_step = ~held & code_rise & ~position_inhibit
    & fifo_in_ready;

  // rotate keeps exactly one bit set
  always_comb begin
    pos_nxt = position_counter;
    grp_nxt = group_counter;
    if (held) begin
      pos_nxt = MKEY_ONEHOT_RST;
      grp_nxt = MKEY_ONEHOT_RST;
    end else begin
      if (pos_step) begin
        pos_nxt = {position_counter[MKEY_NUM_POS-2:0],
                   position_counter[MKEY_NUM_POS-1]};
      end
      if (pos_carry_rise && !group_inhibit) begin
        grp_nxt = {group_counter[MKEY_NUM_GRP-2:0],
                   group_counter[MKEY_NUM_GRP-1]};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      position_counter <= MKEY_ONEHOT_RST;
      group_counter <= MKEY_ONEHOT_RST;
      pos_carry_prev_r <= 1'b1;
      grp_carry_prev_r <= 1'b1;
    end else begin
      position_counter <= pos_nxt;
      group_counter <= grp_nxt;
      pos_carry_prev_r <= pos_carry;
      grp_carry_prev_r <= grp_carry;
    end
  end

  // ==========================================================
  // pattern matrix; standby bit tied low whatever is loaded
  generate
    for (genvar b = 0; b < MKEY_NUM_BITS; b++) begin : g_bit
      if (b == MKEY_STANDBY_BIT) begin : g_stby
        assign store[b] = 1'b0;
      end else begin : g_prog
        assign store[b] = pattern_bits[b];
      end
      assign sel_bits[b] = store[b] & group_counter[b / MKEY_NUM_POS]
        & position_counter[b % MKEY_NUM_POS];
    end
  endgenerate

  assign key_now = |sel_bits;

  // ==========================================================
  // keyed outputs; tone follows key or the manual tone key
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      keyed_out <= MKEY_KEY_RST;
      tone_gate <= MKEY_KEY_RST;
      standby <= 1'b1;
    end else begin
      keyed_out <= key_now;
      tone_gate <= key_now | tone_gate_switch;
      standby <= held;
    end
  end

  // ==========================================================
  // element stream: each step records the position just left
  assign elem_in.key = key_now;
  assign elem_in.grp = mkey_index(group_counter);
  assign elem_in.pos = mkey_index(position_counter);

  mkey_fifo #(
    .WIDTH(MKEY_ELEM_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(pos_step),
    .in_ready(fifo_in_ready),
    .in_data(elem_in),
    .out_valid(elem_valid),
    .out_ready(elem_ready),
    .out_data(elem_data)
  );

endmodule

/* verif/mkey_keyer_props.sv */
`timescale 1ns/100ps

// ============================================================
// keyer port checker
module mkey_keyer_props
  import mkey_pkg::*;
#(
  parameter int DIV_LOG2 = MKEY_DIV_LOG2,
  parameter int FIFO_DEPTH = MKEY_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic code_clk,
  input wire logic interval_clk,
  input wire logic manual_trigger_switch,
  input wire logic tone_gate_switch,
  input wire logic position_inhibit,
  input wire logic group_inhibit,
  input wire logic [MKEY_NUM_BITS-1:0] pattern_bits,
  input wire logic keyed_out,
  input wire logic tone_gate,
  input wire logic standby,
  input wire logic [MKEY_NUM_POS-1:0] position_counter,
  input wire logic [MKEY_NUM_GRP-1:0] group_counter,
  input wire logic elem_valid,
  input wire logic elem_ready,
  input wire mkey_elem_t elem_data
);
  int k;
  logic sel_key;

  function automatic int ix(logic [9:0] oh);
    for (int i = 0; i < 10; i++)
      if (oh[i])
        return i;
    return 0;
  endfunction

  // matrix bit under the counter pair; the standby bit never keys
  always_comb begin
    k = ix(group_counter) * 10 + ix(position_counter);
    sel_key = (k != 0) && pattern_bits[k];
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_pos_onehot: assert property ($onehot(position_counter))
    else $error("position counter not one-hot");
  a_grp_onehot: assert property ($onehot(group_counter))
    else $error("group counter not one-hot");
  a_standby_forces: assert property (standby && $past(standby) |->
    position_counter == 10'h001 && group_counter == 10'h001)
    else $error("counters not held while in standby");
  a_pos_rotates: assert property ($changed(position_counter) &&
    position_counter != 10'h001 |->
    position_counter == $past(position_counter) << 1)
    else $error("position stepped by other than one");
  a_pos_inhibit: assert property (position_inhibit [*2] |=>
    $stable(position_counter) || position_counter == 10'h001)
    else $error("position moved while inhibited");
  a_grp_rotates: assert property ($changed(group_counter) |->
    group_counter == {$past(group_counter[8:0]), $past(group_counter[9])})
    else $error("group stepped by other than one");
  a_trig_start: assert property ($rose(manual_trigger_switch) &&
    standby |-> ##[2:3] !standby)
    else $error("trigger did not release the latch");
  a_key_select: assert property (keyed_out == $past(sel_key))
    else $error("keyed output differs from selected bit");
  // tone and key leave the same flop stage, so they move together
  a_tone_follow: assert property (
    tone_gate == (keyed_out | $past(tone_gate_switch)))
    else $error("tone gate differs from key");

  c_run_start: cover property ($fell(standby));
  c_fifo_stall: cover property (elem_valid && !elem_ready);
  c_key_down: cover property ($rose(keyed_out));
endmodule

bind mkey_keyer mkey_keyer_props #(.DIV_LOG2(DIV_LOG2),
  .FIFO_DEPTH(FIFO_DEPTH)) mkey_keyer_props_i (.*);

/* verif/mkey_sink.sv */
`timescale 1ns/100ps

// ============================================================
// element sink in the transmitter's place
module mkey_sink
  import mkey_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic elem_valid,
  output logic elem_ready,
  input wire mkey_elem_t elem_data
);
  mkey_elem_t got [0:127];
  int n_got;

  // ready drops only while the bench stalls the far side
  assign elem_ready = !stall;

  // log accepted elements in arrival order for later comparison
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      n_got <= 0;
    end else if (elem_valid && elem_ready) begin
      got[n_got[6:0]] <= elem_data;
      n_got <= n_got + 1;
    end
  end
endmodule

/* verif/testbench.sv */
`timescale 1ns/100ps

// ============================================================
// keyer bench
module testbench
  import mkey_pkg::*;
;
  typedef struct {
    int steps;
    logic [9:0] pos;
    logic [9:0] grp;
  } mkey_row_t;
  localparam logic [99:0] PAT = 100'h5_3c96_a5c3_0ff0_9a65_c3a5_5a3f;
  logic sys_clk, rst_b, code_clk, interval_clk, stall;
  logic manual_trigger_switch, tone_gate_switch;
  logic position_inhibit, group_inhibit, keyed_out, tone_gate, standby;
  logic [99:0] pattern_bits;
  logic [9:0] position_counter, group_counter;
  logic elem_valid, elem_ready;
  mkey_elem_t elem_data;
  int err_total, total_checks;
  // code steps to apply, then the one-hot pair they should reach
  mkey_row_t rows [4] = '{'{1, 10'h002, 10'h001}, '{8, 10'h200, 10'h001},
    '{1, 10'h001, 10'h002}, '{9, 10'h200, 10'h002}};

  // divider cut to sixteen base rises so the interval case stays short
  mkey_keyer #(.DIV_LOG2(4)) mkey_keyer_i (.*);
  mkey_sink mkey_sink_i (.*);

  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one code period, long enough for the whole step pipeline to settle
  task automatic code_pulse;
    code_clk = 1;
    tick(4);
    code_clk = 0;
    tick(4);
  endtask

  // bounded wait for the standby flag, optionally clocking code steps
  task automatic wait_sb(input logic lvl, input bit pulse);
    int i;
    for (i = 0; i < 200 && standby !== lvl; i++)
      if (pulse) code_pulse();
      else tick(1);
    if (i == 200) begin
      err_total++;
      stop_test();
    end
  endtask

  function automatic logic ek(int k);
    return (k != 0) && PAT[k];
  endfunction

  initial begin
    int idx;
    rst_b = 0;
    code_clk = 0;
    interval_clk = 0;
    manual_trigger_switch = 1;
    tone_gate_switch = 0;
    position_inhibit = 0;
    group_inhibit = 0;
    stall = 0;
    pattern_bits = PAT;
    tick(5);
    rst_b = 1;
    tick(3);
    // switch held high through reset must not start a run
    chk(standby, 1);
    chk(position_counter, 10'h001);
    chk(group_counter, 10'h001);
    chk(keyed_out, 0);
    $display("reset test done");
    manual_trigger_switch = 0;
    tick(2);
    manual_trigger_switch = 1;
    wait_sb(0, 0);
    manual_trigger_switch = 0;
    idx = 0;
    foreach (rows[r]) begin
      repeat (rows[r].steps) code_pulse();
      idx += rows[r].steps;
      chk(position_counter, rows[r].pos);
      chk(group_counter, rows[r].grp);
      chk(keyed_out, ek(idx));
    end
    $display("table test done");
    // inhibit, then a retrigger in mid-run; neither may move the count
    position_inhibit = 1;
    code_pulse();
    code_pulse();
    position_inhibit = 0;
    manual_trigger_switch = 1;
    tick(4);
    manual_trigger_switch = 0;
    chk(position_counter, 10'h200);
    chk(standby, 0);
    $display("inhibit test done");
    // sink stalls: sixteen elements fit, later code steps are refused
    stall = 1;
    repeat (20) code_pulse();
    chk(group_counter, 10'h008);
    chk(position_counter, 10'h020);
    stall = 0;
    tick(24);
    chk(mkey_sink_i.n_got, 35);
    $display("fifo test done");
    wait_sb(1, 1);
    tick(4);
    chk(group_counter, 10'h001);
    chk(mkey_sink_i.n_got, 100);
    for (int k = 0; k < 100; k++)
      chk(mkey_sink_i.got[k], {ek(k), 4'(k / 10), 4'(k % 10)});
    tone_gate_switch = 1;
    tick(2);
    chk(tone_gate, 1);
    tone_gate_switch = 0;
    $display("run end test done");
    // fifteen base rises leave the latch alone, the sixteenth fires it
    repeat (15) begin
      interval_clk = 1;
      tick(2);
      interval_clk = 0;
      tick(2);
    end
    chk(standby, 1);
    interval_clk = 1;
    tick(2);
    interval_clk = 0;
    wait_sb(0, 0);
    $display("interval test done");
    // group inhibit over a full position pass; one base rise moves
    // the divider so the reset below has something to clear
    group_inhibit = 1;
    interval_clk = 1;
    repeat (10) code_pulse();
    interval_clk = 0;
    chk(position_counter, 10'h001);
    chk(group_counter, 10'h001);
    chk(mkey_keyer_i.div_r, 4'h1);
    chk(standby, 0);
    group_inhibit = 0;
    code_pulse();
    code_pulse();
    $display("group inhibit test done");
    // reset in mid-run drops the run and clears the divider
    rst_b = 0;
    tick(1);
    chk(position_counter, 10'h001);
    chk(elem_valid, 0);
    chk(mkey_keyer_i.div_r, 4'h0);
    rst_b = 1;
    tick(2);
    chk(standby, 1);
    chk(keyed_out, 0);
    chk(tone_gate, 0);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
